//--- rtl/carry_timer.sv
// periodic carry generator for the basic timer
// assumes run is low only while the oscillator is stopped
`timescale 1ns/1ns
module carry_timer #(
  parameter int unsigned CYCLES = standby_pkg::CARRY_CYCLES
)
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // run enable in, carry pulse out
  wake_if.timer_src w
);

  localparam int unsigned CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_q;
  logic             set_q;

  // free count, stops with the oscillator
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      set_q <= 1'b0;
    end
    else if (w.run)
    begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      set_q <= (cnt_q == LAST);
    end
    else
    begin
      set_q <= 1'b0;
    end
  end

  assign w.carry_set = set_q;

  property p_carry_single;
    @(posedge ref_clk) disable iff (rst)
    w.carry_set |=> !w.carry_set;
  endproperty
  a_carry_single : assert property (p_carry_single)
    else $error("carry pulse longer than one cycle");

endmodule : carry_timer

//--- rtl/key_wake_sync.sv
// two-stage synchroniser for the key input wake levels
// assumes key pins already carry their pull-downs outside
`timescale 1ns/1ns
module key_wake_sync
(
  // clock and reset
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  // key pins
  input  wire logic [standby_pkg::KEY_PINS-1:0] key_in,
  // synchronised levels
  wake_if.key_src                               w
);

  logic [standby_pkg::KEY_PINS-1:0] meta_q;
  logic [standby_pkg::KEY_PINS-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= key_in;
      sync_q <= meta_q;
    end
  end

  assign w.key_level = sync_q;

endmodule : key_wake_sync

//--- rtl/standby_halt_release_control.sv
// halt, clock stop and low-speed control for a small cpu core
// assumes one 10 MHz clock, pulses from the cpu core, flags from the interrupt unit
`timescale 1ns/1ns
module standby_halt_release_control #(
  parameter int unsigned CARRY_CYCLES = standby_pkg::CARRY_CYCLES
)
(
  // clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  // cpu core
  input  wire logic                                halt_exec,
  input  wire logic [standby_pkg::OP_W-1:0]        halt_operand,
  input  wire logic                                stop_exec,
  output logic                                     cpu_clk_en,
  output logic                                     cpu_halted,
  output logic                                     resume_next,
  output logic                                     vector_take,
  output logic                                     ce_reset_seq,
  // clocks
  output logic                                     osc_enable,
  output logic                                     periph_clk_en,
  // pins and flags
  input  wire logic [standby_pkg::KEY_PINS-1:0]    key_input_pin,
  input  wire logic                                ce_pin,
  input  wire logic                                ce_reset_req,
  input  wire logic [standby_pkg::INT_SOURCES-1:0] irq_flag,
  input  wire logic [standby_pkg::INT_SOURCES-1:0] interrupt_enable_flag,
  input  wire logic                                global_interrupt_on,
  output logic                                     periodic_timer_carry_flag,
  // register port
  input  wire logic [standby_pkg::ADDR_W-1:0]      reg_addr,
  input  wire logic [standby_pkg::DATA_W-1:0]      reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic [standby_pkg::DATA_W-1:0]           reg_rdata
);

  wake_if w ();

  standby_pkg::standby_state_e      state_q;
  logic [standby_pkg::OP_W-1:0]     op_q;
  logic [standby_pkg::OP_W-1:0]     cause_q;
  logic [standby_pkg::OP_W-1:0]     cond;
  logic [standby_pkg::OP_W-1:0]     hit_now;
  logic [standby_pkg::OP_W-1:0]     hit_new;
  logic [standby_pkg::OP_W-1:0]     hits;
  logic [standby_pkg::DATA_W-1:0]   rdata_d;
  logic [standby_pkg::DATA_W-1:0]   rdata_q;
  logic                             carry_q;
  logic                             low_speed_q;
  logic                             ce_level_q;
  logic                             div_q;
  logic                             resume_q;
  logic                             vector_q;
  logic                             ce_seq_q;
  logic                             int_pending;
  logic                             wake;
  logic                             halted;
  logic                             running;
  logic                             enter_req;
  logic                             leave_halt;
  logic                             skip_halt;
  logic                             go;
  logic                             vec;

  key_wake_sync u_key_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .key_in  (key_input_pin),
    .w       (w.key_src)
  );

  carry_timer #(
    .CYCLES (CARRY_CYCLES)
  ) u_carry_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .w       (w.timer_src)
  );

  // release conditions
  assign int_pending = |(irq_flag & interrupt_enable_flag);
  always_comb
  begin
    cond                         = '0;
    cond[standby_pkg::OP_KEY]    = |w.key_level;
    cond[standby_pkg::OP_TIMER]  = w.carry_set;
    cond[standby_pkg::OP_UNUSED] = 1'b0;
    cond[standby_pkg::OP_INT]    = int_pending;
  end

  assign hit_now    = cond & op_q;
  assign hit_new    = cond & halt_operand;
  assign wake       = |hit_now;
  assign halted     = (state_q == standby_pkg::halt_st);
  assign running    = (state_q == standby_pkg::run_st);
  assign enter_req  = running && halt_exec && !stop_exec && !ce_reset_req;
  assign leave_halt = halted && wake && !ce_reset_req;
  assign skip_halt  = enter_req && (|hit_new);
  assign go         = leave_halt || skip_halt;
  assign hits       = leave_halt ? hit_now : hit_new;
  assign vec        = go && hits[standby_pkg::OP_INT] && global_interrupt_on;

  // standby state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= standby_pkg::run_st;
    end
    else
    begin
      case (state_q)
        standby_pkg::run_st:
        begin
          if (stop_exec && !ce_reset_req)
          begin
            state_q <= standby_pkg::stop_st;
          end
          else if (enter_req && !(|hit_new))
          begin
            state_q <= standby_pkg::halt_st;
          end
        end
        standby_pkg::halt_st:
        begin
          if (ce_reset_req || wake)
          begin
            state_q <= standby_pkg::run_st;
          end
        end
        standby_pkg::stop_st:
        begin
          if (ce_reset_req)
          begin
            state_q <= standby_pkg::run_st;
          end
        end
        default:
        begin
          state_q <= standby_pkg::run_st;
        end
      endcase
    end
  end

  // operand capture
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      op_q <= standby_pkg::OPERAND_RST;
    end
    else if (enter_req)
    begin
      op_q <= halt_operand;
    end
  end

  // exit pulses and cause of last release
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resume_q <= 1'b0;
      vector_q <= 1'b0;
      ce_seq_q <= 1'b0;
      cause_q  <= '0;
    end
    else
    begin
      resume_q <= go && !vec;
      vector_q <= vec;
      ce_seq_q <= ce_reset_req;
      if (go)
      begin
        cause_q <= hits;
      end
    end
  end

  // carry flag, set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      carry_q <= 1'b0;
    end
    else if (w.carry_set)
    begin
      carry_q <= 1'b1;
    end
    else if (reg_wr && reg_addr == standby_pkg::CARRY_ADDR && reg_wdata[standby_pkg::CARRY_BIT])
    begin
      carry_q <= 1'b0;
    end
  end

  // control register and low-speed divider
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      low_speed_q <= standby_pkg::LOW_SPEED_RST;
      div_q       <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == standby_pkg::CONTROL_ADDR)
      begin
        low_speed_q <= reg_wdata[standby_pkg::LOW_SPEED_BIT];
      end
      div_q <= !div_q;
    end
  end

  // chip-enable level sample
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ce_level_q <= 1'b0;
    end
    else
    begin
      ce_level_q <= ce_pin;
    end
  end

  // register read
  always_comb
  begin
    rdata_d = '0;
    case (reg_addr)
      standby_pkg::CE_STATUS_ADDR:  rdata_d[standby_pkg::CE_LEVEL_BIT]  = ce_level_q;
      standby_pkg::CONTROL_ADDR:    rdata_d[standby_pkg::LOW_SPEED_BIT] = low_speed_q;
      standby_pkg::CARRY_ADDR:      rdata_d[standby_pkg::CARRY_BIT]     = carry_q;
      standby_pkg::STANDBY_ADDR:
      begin
        rdata_d[standby_pkg::HALTED_BIT] = halted;
        rdata_d[standby_pkg::OSC_ON_BIT] = osc_enable;
        rdata_d[standby_pkg::SLOW_BIT]   = low_speed_q;
      end
      standby_pkg::WAKE_CAUSE_ADDR: rdata_d = cause_q;
      default:                      rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= reg_rd ? rdata_d : '0;
    end
  end

  // outputs
  assign osc_enable                = (state_q != standby_pkg::stop_st);
  assign periph_clk_en             = osc_enable;
  assign w.run                     = osc_enable;
  assign cpu_clk_en                = running && (!low_speed_q || div_q);
  assign cpu_halted                = halted;
  assign resume_next               = resume_q;
  assign vector_take               = vector_q;
  assign ce_reset_seq              = ce_seq_q;
  assign periodic_timer_carry_flag = carry_q;
  assign reg_rdata                 = rdata_q;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_leave_normal;
    halted && wake && !ce_reset_req && !(hit_now[standby_pkg::OP_INT] && global_interrupt_on);
  endsequence

  sequence s_resumed;
    !cpu_halted && resume_next && !vector_take;
  endsequence

  property p_halt_no_step;
    halted |-> !cpu_clk_en;
  endproperty
  a_halt_no_step : assert property (p_halt_no_step)
    else $error("cpu stepped while halted");

  property p_op_load;
    (enter_req && !(|hit_new)) |=> (halted && op_q == $past(halt_operand));
  endproperty
  a_op_load : assert property (p_op_load)
    else $error("halt operand not captured");

  property p_masked;
    (halted && !(|(cond & op_q)) && !ce_reset_req) |=> halted;
  endproperty
  a_masked : assert property (p_masked)
    else $error("halt ended by a source not armed");

  property p_resume;
    s_leave_normal |=> s_resumed;
  endproperty
  a_resume : assert property (p_resume)
    else $error("no resume after release");

  property p_any_source;
    (halted && (|hit_now) && !ce_reset_req) |=> (!cpu_halted && (resume_next || vector_take));
  endproperty
  a_any_source : assert property (p_any_source)
    else $error("enabled source did not end halt");

  property p_ce_reset;
    (halted && ce_reset_req) |=> (!halted && ce_reset_seq && !resume_next && !vector_take);
  endproperty
  a_ce_reset : assert property (p_ce_reset)
    else $error("chip-enable reset did not end halt");

  property p_zero_op;
    (halted && op_q == 4'h0 && !ce_reset_req) |=> halted;
  endproperty
  a_zero_op : assert property (p_zero_op)
    else $error("zero operand halt ended without reset");

  property p_key_level;
    (enter_req && halt_operand[standby_pkg::OP_KEY] && (|w.key_level)) |=> (!halted && (resume_next || vector_take));
  endproperty
  a_key_level : assert property (p_key_level)
    else $error("high key did not prevent halt");

  property p_timer_wake;
    (halted && op_q[standby_pkg::OP_TIMER] && w.carry_set) |=> (!halted && periodic_timer_carry_flag);
  endproperty
  a_timer_wake : assert property (p_timer_wake)
    else $error("carry did not end halt with flag set");

  property p_int_vector;
    (halted && op_q[standby_pkg::OP_INT] && int_pending && !ce_reset_req) |=> (vector_take == $past(global_interrupt_on));
  endproperty
  a_int_vector : assert property (p_int_vector)
    else $error("interrupt wake took wrong path");

  property p_stop;
    (running && stop_exec && !ce_reset_req) |=> (!osc_enable && !periph_clk_en && !cpu_clk_en);
  endproperty
  a_stop : assert property (p_stop)
    else $error("clock stop left oscillator on");

  property p_low_speed;
    (low_speed_q && running && cpu_clk_en && !stop_exec && !halt_exec && !reg_wr) |=> !cpu_clk_en ##1 (cpu_clk_en || !running);
  endproperty
  a_low_speed : assert property (p_low_speed)
    else $error("low-speed cadence wrong");

  property p_ce_flag;
    (reg_rd && reg_addr == standby_pkg::CE_STATUS_ADDR) |=> (reg_rdata[0] == $past(ce_level_q));
  endproperty
  a_ce_flag : assert property (p_ce_flag)
    else $error("chip-enable status bit wrong");

endmodule : standby_halt_release_control

//--- rtl/standby_pkg.sv
// constants for the standby and halt release controller
// assumes a 10 MHz reference clock and a 4-bit register port
package standby_pkg;

  // reference clock and periodic carry timing
  localparam int unsigned REF_CLK_HZ       = 10_000_000;
  localparam int unsigned CARRY_PERIOD_MS  = 125;
  localparam int unsigned CARRY_CYCLES     = REF_CLK_HZ / 1000 * CARRY_PERIOD_MS;

  // halt operand bit positions
  localparam int unsigned OP_W             = 4;
  localparam int unsigned OP_KEY           = 0;
  localparam int unsigned OP_TIMER         = 1;
  localparam int unsigned OP_UNUSED        = 2;
  localparam int unsigned OP_INT           = 3;

  // pin counts
  localparam int unsigned KEY_PINS         = 4;
  localparam int unsigned INT_SOURCES      = 3;

  // register port
  localparam int unsigned ADDR_W           = 4;
  localparam int unsigned DATA_W           = 4;
  localparam logic [3:0]  CE_STATUS_ADDR   = 4'h0;
  localparam logic [3:0]  CONTROL_ADDR     = 4'h1;
  localparam logic [3:0]  CARRY_ADDR       = 4'h2;
  localparam logic [3:0]  STANDBY_ADDR     = 4'h3;
  localparam logic [3:0]  WAKE_CAUSE_ADDR  = 4'h4;

  // field positions
  localparam int unsigned CE_LEVEL_BIT     = 0;
  localparam int unsigned LOW_SPEED_BIT    = 0;
  localparam int unsigned CARRY_BIT        = 0;
  localparam int unsigned HALTED_BIT       = 0;
  localparam int unsigned OSC_ON_BIT       = 1;
  localparam int unsigned SLOW_BIT         = 2;

  // reset values
  localparam logic        LOW_SPEED_RST    = 1'b0;
  localparam logic [3:0]  OPERAND_RST      = 4'h0;

  typedef enum logic [1:0] {
    run_st,
    halt_st,
    stop_st
  } standby_state_e;

endpackage : standby_pkg

//--- rtl/wake_if.sv
// carrier between the controller and its wake source helpers
// assumes one clock shared by all parties
`timescale 1ns/1ns
interface wake_if;
  logic [standby_pkg::KEY_PINS-1:0] key_level;
  logic                             carry_set;
  logic                             run;

  modport key_src   (output key_level);
  modport timer_src (input run, output carry_set);
  modport core      (input key_level, input carry_set, output run);
endinterface : wake_if

//--- verif/cpu_side_model.sv
// far side model: cpu step counter and key pins with pull-downs
// assumes the controller drives cpu_clk_en and the resume pulses
`timescale 1ns/1ns
module cpu_side_model #(
  parameter logic [7:0] VECTOR_PC = 8'h02
)
(
  // clock and reset
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  // controller side
  input  wire logic                             cpu_clk_en,
  input  wire logic                             vector_take,
  input  wire logic                             ce_reset_seq,
  // key sources
  input  wire logic [standby_pkg::KEY_PINS-1:0] key_drive,
  input  wire logic [standby_pkg::KEY_PINS-1:0] key_oe,
  output logic [standby_pkg::KEY_PINS-1:0]      key_input_pin,
  output logic [7:0]                            pc_q
);
  // released key pins fall to the pull-down level
  assign key_input_pin = key_drive & key_oe;

  // program counter moves on cpu steps, loads VECTOR_PC on vector_take and clears on ce_reset_seq
  always_ff @(posedge ref_clk)
  begin
    if (rst || ce_reset_seq)
    begin
      pc_q <= 8'h00;
    end
    else if (vector_take)
    begin
      pc_q <= VECTOR_PC;
    end
    else if (cpu_clk_en)
    begin
      pc_q <= pc_q + 8'h01;
    end
  end
endmodule : cpu_side_model

//--- verif/standby_halt_release_control_tb.sv
// table driven bench for the standby and halt release controller
// assumes carry period shortened to 20 cycles
`timescale 1ns/1ns
module standby_halt_release_control_tb;
  localparam int unsigned CY = 20;
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] key;
    logic [2:0] irq;
    logic [2:0] ie;
    logic       gie;
    logic [1:0] res;
    logic       cy;
  } row_s;

  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       halt_exec = 1'b0;
  logic [3:0] halt_operand = 4'h0;
  logic       stop_exec = 1'b0;
  logic       ce_pin = 1'b0;
  logic       ce_reset_req = 1'b0;
  logic [2:0] irq_flag = 3'h0;
  logic [2:0] interrupt_enable_flag = 3'h0;
  logic       global_interrupt_on = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [3:0] reg_wdata = 4'h0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [3:0] key_drive = 4'h0;
  logic [3:0] key_oe = 4'h0;
  logic [3:0] key_input_pin;
  logic [3:0] reg_rdata;
  logic [7:0] pc_q;
  logic [7:0] pc_hold;
  logic       cpu_clk_en, cpu_halted, resume_next, vector_take, ce_reset_seq;
  logic       osc_enable, periph_clk_en, periodic_timer_carry_flag;
  logic [1:0] res;
  row_s       rows [11];
  int         fail_count = 0;
  int         comparisons = 0;
  int         n;
  time        t1;

  always #50 ref_clk = ~ref_clk;

  standby_halt_release_control #(.CARRY_CYCLES(CY)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .halt_exec(halt_exec), .halt_operand(halt_operand),
    .stop_exec(stop_exec), .cpu_clk_en(cpu_clk_en), .cpu_halted(cpu_halted),
    .resume_next(resume_next), .vector_take(vector_take), .ce_reset_seq(ce_reset_seq),
    .osc_enable(osc_enable), .periph_clk_en(periph_clk_en), .key_input_pin(key_input_pin),
    .ce_pin(ce_pin), .ce_reset_req(ce_reset_req), .irq_flag(irq_flag),
    .interrupt_enable_flag(interrupt_enable_flag), .global_interrupt_on(global_interrupt_on),
    .periodic_timer_carry_flag(periodic_timer_carry_flag), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  cpu_side_model u_cpu (
    .ref_clk(ref_clk), .rst(rst), .cpu_clk_en(cpu_clk_en), .vector_take(vector_take),
    .ce_reset_seq(ce_reset_seq), .key_drive(key_drive), .key_oe(key_oe),
    .key_input_pin(key_input_pin), .pc_q(pc_q));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [3:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check(8'(reg_rdata), 8'(exp));
  endtask : rd_chk

  task automatic pulse_ce;
    @(posedge ref_clk);
    ce_reset_req <= 1'b1;
    @(posedge ref_clk);
    ce_reset_req <= 1'b0;
    @(negedge ref_clk);
  endtask : pulse_ce

  // issue one halt and watch for the way out
  task automatic halt_watch(input logic [3:0] op);
    @(posedge ref_clk);
    halt_exec <= 1'b1;
    halt_operand <= op;
    @(posedge ref_clk);
    halt_exec <= 1'b0;
    res = 2'h0;
    for (int i = 0; i < 40 && res == 2'h0; i++)
    begin
      @(negedge ref_clk);
      if (i == 0)
        pc_hold = pc_q;
      if (vector_take === 1'b1)
        res = 2'h2;
      else if (resume_next === 1'b1)
        res = 2'h1;
    end
  endtask : halt_watch

  task automatic close_out;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  initial
  begin
    // op, key, irq, ie, gie, result (0 stay, 1 resume, 2 vector), carry set
    rows[0]  = {4'h0, 4'hF, 3'h7, 3'h7, 1'b1, 2'h0, 1'b0};
    rows[1]  = {4'h1, 4'h1, 3'h0, 3'h0, 1'b0, 2'h1, 1'b0};
    rows[2]  = {4'h1, 4'h8, 3'h0, 3'h0, 1'b1, 2'h1, 1'b0};
    rows[3]  = {4'h2, 4'h0, 3'h0, 3'h0, 1'b0, 2'h1, 1'b1};
    rows[4]  = {4'h8, 4'h0, 3'h1, 3'h1, 1'b0, 2'h1, 1'b0};
    rows[5]  = {4'h8, 4'h0, 3'h4, 3'h4, 1'b1, 2'h2, 1'b0};
    rows[6]  = {4'h8, 4'h0, 3'h1, 3'h2, 1'b1, 2'h0, 1'b0};
    rows[7]  = {4'h4, 4'hF, 3'h7, 3'h7, 1'b1, 2'h0, 1'b0};
    rows[8]  = {4'hB, 4'h0, 3'h0, 3'h0, 1'b1, 2'h1, 1'b1};
    rows[9]  = {4'h2, 4'hF, 3'h3, 3'h3, 1'b1, 2'h1, 1'b1};
    rows[10] = {4'h9, 4'h0, 3'h2, 3'h2, 1'b1, 2'h2, 1'b0};
    cyc(6);
    rst <= 1'b0;
    cyc(2);
    foreach (rows[r])
    begin
      @(posedge ref_clk);
      key_drive <= rows[r].key;
      key_oe <= 4'hF;
      irq_flag <= rows[r].irq;
      interrupt_enable_flag <= rows[r].ie;
      global_interrupt_on <= rows[r].gie;
      ce_pin <= r[0];
      cyc(4);
      wr(standby_pkg::CARRY_ADDR, 4'h1);
      halt_watch(rows[r].op);
      check(8'(res), 8'(rows[r].res));
      if (rows[r].cy)
        check(8'(periodic_timer_carry_flag), 8'h01);
      if (res == 2'h0)
      begin
        check(8'({cpu_halted, cpu_clk_en, periph_clk_en}), 8'h05);
        check(pc_q, pc_hold);
        pulse_ce();
        check(8'({ce_reset_seq, cpu_halted, resume_next, vector_take}), 8'h08);
      end
      @(posedge ref_clk);
      key_oe <= 4'h0;
      irq_flag <= 3'h0;
      interrupt_enable_flag <= 3'h0;
      cyc(4);
    end
    // interrupt raised while halted vectors
    interrupt_enable_flag <= 3'h2;
    global_interrupt_on <= 1'b1;
    @(posedge ref_clk);
    halt_exec <= 1'b1;
    halt_operand <= 4'h8;
    @(posedge ref_clk);
    halt_exec <= 1'b0;
    cyc(3);
    irq_flag <= 3'h2;
    @(negedge ref_clk);
    check(8'(cpu_halted), 8'h01);
    @(negedge ref_clk);
    check(8'({cpu_halted, vector_take, resume_next}), 8'h02);
    rd_chk(standby_pkg::WAKE_CAUSE_ADDR, 4'h8);
    @(posedge ref_clk);
    irq_flag <= 3'h0;
    interrupt_enable_flag <= 3'h0;
    // power-on reset in mid-halt
    halt_watch(4'h0);
    check(8'(cpu_halted), 8'h01);
    @(posedge ref_clk);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    @(negedge ref_clk);
    check({cpu_halted, cpu_clk_en, osc_enable, periodic_timer_carry_flag, reg_rdata}, 8'h60);
    check(pc_q, 8'h00);
    // chip-enable level and unmapped place
    @(posedge ref_clk);
    ce_pin <= 1'b1;
    rd_chk(standby_pkg::CE_STATUS_ADDR, 4'h1);
    @(posedge ref_clk);
    ce_pin <= 1'b0;
    rd_chk(standby_pkg::CE_STATUS_ADDR, 4'h0);
    rd_chk(4'hF, 4'h0);
    // low speed runs at half rate
    wr(standby_pkg::CONTROL_ADDR, 4'h1);
    n = 0;
    repeat (10)
    begin
      @(negedge ref_clk);
      n += int'(cpu_clk_en === 1'b1);
    end
    check(8'(n), 8'h05);
    rd_chk(standby_pkg::STANDBY_ADDR, 4'h6);
    wr(standby_pkg::CONTROL_ADDR, 4'h0);
    // carry period and clear
    wr(standby_pkg::CARRY_ADDR, 4'h1);
    @(negedge ref_clk);
    for (int i = 0; i < 50 && periodic_timer_carry_flag !== 1'b1; i++)
      @(negedge ref_clk);
    check(8'(periodic_timer_carry_flag), 8'h01);
    t1 = $time;
    wr(standby_pkg::CARRY_ADDR, 4'h1);
    @(negedge ref_clk);
    check(8'(periodic_timer_carry_flag), 8'h00);
    for (int i = 0; i < 50 && periodic_timer_carry_flag !== 1'b1; i++)
      @(negedge ref_clk);
    check(8'(periodic_timer_carry_flag), 8'h01);
    check(8'(($time - t1) / 100), 8'(CY));
    rd_chk(standby_pkg::CARRY_ADDR, 4'h1);
    // clock stop and chip-enable return
    @(posedge ref_clk);
    stop_exec <= 1'b1;
    @(posedge ref_clk);
    stop_exec <= 1'b0;
    @(negedge ref_clk);
    check(8'({osc_enable, periph_clk_en, cpu_clk_en}), 8'h00);
    cyc(3);
    check(8'(periodic_timer_carry_flag), 8'h01);
    pulse_ce();
    @(negedge ref_clk);
    check(8'({osc_enable, periph_clk_en, cpu_clk_en}), 8'h07);
    close_out();
  end
endmodule : standby_halt_release_control_tb
